// >>> src/qpx_pkg.sv
// Purpose: shared constants and types for the quasi-bidirectional port expander slave
// Assumes: 100 MHz clk_i; bus lines sampled, never used as clocks
// Notes: port snapshot for the interrupt is retaken once written pins settle
package qpx_pkg;

  // ************************************************************
  // Constants
  // ************************************************************
  localparam int unsigned QPX_BYTE_BITS = 8;
  localparam logic [2:0] QPX_LAST_BIT = 3'h7;
  localparam logic [7:0] QPX_PORT_RESET = 8'hFF;
  localparam int unsigned QPX_SYNC_STAGES = 2;
  localparam int unsigned QPX_FIFO_DEPTH = 32;
  localparam logic [4:0] QPX_ADDR_FIXED_DEFAULT = 5'h04;
  localparam logic [2:0] QPX_SETTLE_CYCLES = 3'h4;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [6:0] {
    QPX_IDLE = 7'b000_0001,
    QPX_ADDR = 7'b000_0010,
    QPX_AACK = 7'b000_0100,
    QPX_WBYTE = 7'b000_1000,
    QPX_WACK = 7'b001_0000,
    QPX_RBYTE = 7'b010_0000,
    QPX_RACK = 7'b100_0000
  } qpx_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } qpx_bus_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic scl_rise;
    logic scl_fall;
  } qpx_evt_t;

endpackage

// >>> src/qpx_fifo.sv
// Purpose: small synchronous FIFO with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: DEPTH must be a power of two
`timescale 1ns/10ps
`default_nettype none
module qpx_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> src/qpx_expander.sv
// Purpose: serial-bus slave for an 8-bit quasi-bidirectional port expander
// Assumes: bus and port pins asynchronous to clk_i; open-drain drivers outside
// Notes: written bytes queue in a FIFO before reaching the port latch
`timescale 1ns/10ps
`default_nettype none
module qpx_expander
  import qpx_pkg::*;
#(
  parameter logic [4:0] ADDR_FIXED = QPX_ADDR_FIXED_DEFAULT,
  parameter int unsigned FIFO_DEPTH = QPX_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic [1:0] addr_sel_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [7:0] port_pin_i,
  output logic [7:0] port_pin_o,
  output logic [7:0] port_pin_oe_o,
  output logic [7:0] port_boost_o,
  output logic int_n_o,
  output logic int_n_oe_o
);

  // ************************************************************
  // Synchronisers
  // ************************************************************
  qpx_bus_t bus_s1_q;
  qpx_bus_t bus_s2_q;
  qpx_bus_t bus_prev_q;
  logic [7:0] pin_s1_q;
  logic [7:0] pin_s2_q;
  logic rstn_s1_q;
  logic rstn_s2_q;
  logic [1:0] asel_s1_q;
  logic [1:0] asel_s2_q;

  always_ff @(posedge clk_i) begin
    bus_s1_q <= '{scl: scl_i, sda: sda_i};
    bus_s2_q <= bus_s1_q;
    pin_s1_q <= port_pin_i;
    pin_s2_q <= pin_s1_q;
    rstn_s1_q <= reset_n_i;
    rstn_s2_q <= rstn_s1_q;
    asel_s1_q <= addr_sel_i;
    asel_s2_q <= asel_s1_q;
  end

  wire soft_rst = rst_i || !rstn_s2_q;

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      bus_prev_q <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      bus_prev_q <= bus_s2_q;
    end
  end

  // ************************************************************
  // Bus events
  // ************************************************************
  qpx_evt_t evt;
  assign evt.start = bus_prev_q.scl && bus_s2_q.scl && bus_prev_q.sda && !bus_s2_q.sda;
  assign evt.stop = bus_prev_q.scl && bus_s2_q.scl && !bus_prev_q.sda && bus_s2_q.sda;
  assign evt.scl_rise = !bus_prev_q.scl && bus_s2_q.scl;
  assign evt.scl_fall = bus_prev_q.scl && !bus_s2_q.scl;

  // ************************************************************
  // Protocol state
  // ************************************************************
  qpx_state_t state_q;
  qpx_state_t state_d;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic [7:0] port_q;
  logic int_clr_q;
  logic int_clr_d;

  wire last_bit = (bit_q == QPX_LAST_BIT);
  wire [7:0] shift_in = {shift_q[6:0], bus_s2_q.sda};
  wire addr_hit = (shift_in[7:1] == {ADDR_FIXED, asel_s2_q});
  wire fifo_in_ready;
  wire fifo_push = (state_q == QPX_WACK) && evt.scl_fall;
  wire [7:0] fifo_out;
  wire fifo_out_valid;
  wire [7:0] read_val = pin_s2_q;

  // One bus bit fully processed per SCL phase; FIFO drains at clk rate so
  // back-pressure only withholds the acknowledge on a write byte.
  always_comb begin
    state_d = state_q;
    bit_d = bit_q;
    shift_d = shift_q;
    sda_oe_d = sda_oe_q;
    int_clr_d = 1'b0;
    if (evt.start) begin
      state_d = QPX_ADDR;
      bit_d = '0;
      sda_oe_d = 1'b0;
    end else if (evt.stop) begin
      state_d = QPX_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        QPX_IDLE: begin
          sda_oe_d = 1'b0;
        end
        QPX_ADDR: begin
          if (evt.scl_rise) begin
            shift_d = shift_in;
            bit_d = bit_q + 3'h1;
          end
          if (evt.scl_rise && last_bit) begin
            if (addr_hit) begin
              state_d = QPX_AACK;
            end else begin
              state_d = QPX_IDLE;
            end
          end
        end
        QPX_AACK: begin
          if (evt.scl_fall) begin
            if (sda_oe_q) begin
              sda_oe_d = 1'b0;
              bit_d = '0;
              if (shift_q[0]) begin
                state_d = QPX_RBYTE;
                shift_d = read_val;
                sda_oe_d = !read_val[7];
                int_clr_d = 1'b1;
              end else begin
                state_d = QPX_WBYTE;
              end
            end else begin
              sda_oe_d = 1'b1;
            end
          end
        end
        QPX_WBYTE: begin
          if (evt.scl_rise) begin
            shift_d = shift_in;
            bit_d = bit_q + 3'h1;
            if (last_bit) begin
              state_d = QPX_WACK;
            end
          end
        end
        QPX_WACK: begin
          if (evt.scl_fall) begin
            if (sda_oe_q) begin
              sda_oe_d = 1'b0;
              state_d = QPX_WBYTE;
              int_clr_d = 1'b1;
            end else begin
              sda_oe_d = fifo_in_ready;
            end
          end
        end
        QPX_RBYTE: begin
          if (evt.scl_fall) begin
            bit_d = bit_q + 3'h1;
            if (last_bit) begin
              state_d = QPX_RACK;
              sda_oe_d = 1'b0;
            end else begin
              shift_d = {shift_q[6:0], 1'b1};
              sda_oe_d = !shift_q[6];
            end
          end
        end
        QPX_RACK: begin
          if (evt.scl_rise) begin
            if (bus_s2_q.sda) begin
              state_d = QPX_IDLE;
            end else begin
              shift_d = read_val;
              int_clr_d = 1'b1;
            end
          end
          if (evt.scl_fall) begin
            state_d = QPX_RBYTE;
            bit_d = '0;
            sda_oe_d = !shift_q[7];
          end
        end
        default: begin
          state_d = QPX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      state_q <= QPX_IDLE;
      bit_q <= '0;
      shift_q <= '0;
      sda_oe_q <= 1'b0;
      int_clr_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      sda_oe_q <= sda_oe_d;
      int_clr_q <= int_clr_d;
    end
  end

  // ************************************************************
  // Write path
  // ************************************************************
  qpx_fifo #(
    .WIDTH(QPX_BYTE_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(soft_rst),
    .in_data_i(shift_q),
    .in_valid_i(fifo_push && sda_oe_q),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(1'b1)
  );

  logic [7:0] boost_q;
  logic [7:0] snap_q;
  logic int_n_q;
  logic [2:0] settle_q;

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      port_q <= QPX_PORT_RESET;
      boost_q <= '0;
    end else if (fifo_out_valid) begin
      port_q <= fifo_out;
      boost_q <= fifo_out & ~port_q;
    end else if (evt.scl_fall) begin
      boost_q <= '0;
    end
  end

  // ************************************************************
  // Interrupt
  // ************************************************************
  // Snapshot is the last value seen by the master; reset snapshot is all ones
  // so externally low inputs raise the interrupt straight after reset.
  // A write moves the pins only after the output register and the pin
  // synchroniser, so the snapshot is retaken once that path has settled.
  wire pin_diff = (pin_s2_q != snap_q);
  wire settling = (settle_q != 3'h0);
  wire snap_take = int_clr_q || (settle_q == 3'h1);
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      snap_q <= QPX_PORT_RESET;
      int_n_q <= 1'b1;
      settle_q <= 3'h0;
    end else begin
      if (fifo_out_valid) begin
        settle_q <= QPX_SETTLE_CYCLES;
      end else if (settling) begin
        settle_q <= settle_q - 3'h1;
      end
      if (snap_take) begin
        snap_q <= pin_s2_q;
      end
      int_n_q <= !(pin_diff && !int_clr_q && !fifo_out_valid && !settling);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      port_pin_o <= '0;
      port_pin_oe_o <= '0;
      port_boost_o <= '0;
      int_n_o <= 1'b0;
      int_n_oe_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
      sda_oe_o <= sda_oe_d;
      port_pin_o <= '0;
      port_pin_oe_o <= ~port_q;
      port_boost_o <= boost_q;
      int_n_o <= 1'b0;
      int_n_oe_o <= !int_n_q;
    end
  end
endmodule
`default_nettype wire

// >>> verification/qpx_expander_properties.sv
// Purpose: port-level protocol checks for the expander slave
// Assumes: 100 MHz clk_i, SCL far slower than clk_i
// Notes: bound into every qpx_expander instance
`timescale 1ns/10ps
`default_nettype none
module qpx_expander_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic scl_i,
  input wire logic [7:0] port_pin_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic [7:0] port_pin_o,
  input wire logic [7:0] port_pin_oe_o,
  input wire logic [7:0] port_boost_o,
  input wire logic int_n_o,
  input wire logic int_n_oe_o
);
  logic [7:0] pins_q;
  logic [3:0] quiet_q;
  // ********
  // Cycles since pins last moved
  // ********
  always_ff @(posedge clk_i) begin
    pins_q <= port_pin_i;
    if (rst_i || !reset_n_i || port_pin_i != pins_q) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i || !reset_n_i);
  a_drive_zero: assert property (!sda_o && port_pin_o == 8'h00 && !int_n_o)
    else $error("open-drain level high");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
    !sda_oe_o && port_pin_oe_o == 8'h00 && !int_n_oe_o) else $error("active in reset");
  a_ack_hold: assert property (scl_i && sda_oe_o |=> sda_oe_o)
    else $error("SDA let go in SCL high");
  a_oe_rise_low: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("SDA pulled in SCL high");
  a_oe_fall_low: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("SDA freed in SCL high");
  a_boost_excl: assert property ((port_boost_o & port_pin_oe_o) == 8'h00)
    else $error("boost on a pulled pin");
  a_boost_end: assert property (port_boost_o != 8'h00 && $fell(scl_i) |->
    ##[1:6] port_boost_o == 8'h00) else $error("boost past SCL fall");
  a_int_cause: assert property ($rose(int_n_oe_o) |-> quiet_q < 4'h8)
    else $error("interrupt without pin change");
endmodule
bind qpx_expander qpx_expander_properties i_qpx_expander_properties (.clk_i, .rst_i,
  .reset_n_i, .scl_i, .port_pin_i, .sda_o, .sda_oe_o, .port_pin_o, .port_pin_oe_o,
  .port_boost_o, .int_n_o, .int_n_oe_o);
`default_nettype wire

// >>> verification/qpx_host.sv
// Purpose: behavioural bus master facing the expander
// Assumes: 125 ns SCL period, SDA pulled up outside
// Notes: SCL stands high between frames
`timescale 1ns/10ps
`default_nettype none
module qpx_host (
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  localparam realtime QTR = 31.25;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // ********
  // Bit and byte level
  // ********
  task automatic send_bit(input logic b, output logic r);
    sda_low_o = !b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  // Also serves as repeated START
  task automatic start_cond();
    sda_low_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b1;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask
  task automatic stop_cond();
    sda_low_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_low_o = 1'b0;
    #QTR;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i], r);
    end
    send_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      send_bit(1'b1, d[i]);
    end
    send_bit(!ack, r);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Purpose: self-checking bench for the port expander slave
// Assumes: 100 MHz clock, pins pulled up unless pulled down
// Notes: no random stimulus
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import qpx_pkg::*;
;
  typedef struct packed {logic [7:0] wr; logic [7:0] ext; logic [7:0] rd;} qpx_row_t;
  localparam logic [7:0] ADDR_W = {QPX_ADDR_FIXED_DEFAULT, 2'b01, 1'b0};
  qpx_row_t rows [4] = '{'{8'hFF, 8'hA5, 8'hA5}, '{8'h3C, 8'hFF, 8'h3C},
    '{8'h0F, 8'hF0, 8'h00}, '{8'hA3, 8'h5E, 8'h02}};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic [7:0] ext_pins = 8'hFF;
  logic scl, sda_low, sda_oe, int_oe, ack;
  logic [7:0] pin_oe, got;
  wire logic sda = !(sda_oe || sda_low);
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  always #5 clk_i = !clk_i;
  qpx_expander i_qpx_expander (.clk_i(clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i),
    .addr_sel_i(2'b01), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .port_pin_i(ext_pins & ~pin_oe), .port_pin_o(), .port_pin_oe_o(pin_oe),
    .port_boost_o(), .int_n_o(), .int_n_oe_o(int_oe));
  qpx_host i_qpx_host (.sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  // ********
  // Helpers
  // ********
  task automatic print_verdict();
    $display("Errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic write_port(input logic [7:0] d, input int n);
    i_qpx_host.start_cond();
    i_qpx_host.put_byte(ADDR_W, ack);
    chk({7'h00, ack}, 8'h01);
    for (int i = n - 1; i >= 0; i--) begin
      i_qpx_host.put_byte(d ^ 8'(i), ack);
      chk({7'h00, ack}, 8'h01);
    end
    i_qpx_host.stop_cond();
    idle(4);
  endtask
  // ********
  // Sequence
  // ********
  initial begin
    idle(16);
    rst_i = 1'b0;
    chk(pin_oe, 8'h00);
    chk({6'h00, sda_oe, int_oe}, 8'h00);
    foreach (rows[i]) begin
      write_port(rows[i].wr, 1);
      chk(pin_oe, ~rows[i].wr);
      ext_pins = rows[i].ext;
      idle(10);
      i_qpx_host.start_cond();
      i_qpx_host.put_byte(ADDR_W | 8'h01, ack);
      i_qpx_host.get_byte(1'b0, got);
      i_qpx_host.stop_cond();
      chk(got, rows[i].rd);
      idle(10);
      chk({7'h00, int_oe}, 8'h00);
    end
    ext_pins = 8'hFF;
    write_port(8'hFF, 3);
    chk(pin_oe, 8'h00);
    ext_pins = 8'hFE;
    idle(10);
    chk({7'h00, int_oe}, 8'h01);
    ext_pins = 8'hFF;
    idle(10);
    chk({7'h00, int_oe}, 8'h00);
    ext_pins = 8'h5A;
    idle(10);
    chk({7'h00, int_oe}, 8'h01);
    i_qpx_host.start_cond();
    i_qpx_host.put_byte({QPX_ADDR_FIXED_DEFAULT, 2'b10, 1'b0}, ack);
    chk({7'h00, ack}, 8'h00);
    i_qpx_host.put_byte(8'h00, ack);
    chk({7'h00, ack}, 8'h00);
    i_qpx_host.start_cond();
    i_qpx_host.put_byte(ADDR_W | 8'h01, ack);
    i_qpx_host.get_byte(1'b1, got);
    chk(got, 8'h5A);
    i_qpx_host.get_byte(1'b0, got);
    chk(got, 8'h5A);
    idle(4);
    chk({7'h00, sda_oe}, 8'h00);
    i_qpx_host.stop_cond();
    idle(10);
    chk({7'h00, int_oe}, 8'h00);
    chk(pin_oe, 8'h00);
    write_port(8'h00, 1);
    chk(pin_oe, 8'hFF);
    reset_n_i = 1'b0;
    idle(4);
    reset_n_i = 1'b1;
    idle(6);
    chk(pin_oe, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
